//--- common/modem_status_consts.svh
// register offsets, field positions and timing counts of the modem status and control block
`ifndef MODEM_STATUS_CONSTS_SVH
`define MODEM_STATUS_CONSTS_SVH
`define OFS_EVENT_STATUS 8'hC6
`define OFS_MODEM_CONFIG 8'hC7
`define OFS_BLOCK_LOAD 8'hC8
`define OFS_IRQ_MASK 8'hCE
`define BIT_IRQ 15
`define BIT_DTMF 12
`define BIT_AUX2 9
`define BIT_AUX1 8
`define BIT_DATA_END 7
`define BIT_DATA_RDY 6
`define BIT_CRC 5
`define BIT_RATE_2K4 4
`define BIT_RATE_1K2 3
`define BIT_PORT_FREE 0
`define CLEAR_ON_READ 16'hFFFC
`define STATUS_EVENTS 16'h13F8
`define CFG_WRITABLE 16'hE7E7
`define BIT_PAT_C 15
`define BIT_PAT_D 14
`define BIT_PAT_T 13
`define BIT_RAW 10
`define BIT_LAST 9
`define BIT_INTERLEAVE 8
`define FMT_HI 7
`define FMT_LO 5
`define BIT_USER 2
`define SEED_HI 1
`define SEED_LO 0
`define FMT_RAW 3'h0
`define FMT_HEAD_ONLY 3'h1
`define FMT_UNSIZED_RAW 3'h2
`define FMT_UNSIZED_FEC 3'h3
`define FMT_SIZED_CRC 3'h4
`define FMT_SIZED_ILV 3'h5
`define SEED_STANDARD 16'hFFFF
`define SEED_NONE 16'h0000
`define PROG_BUSY_NS 64
`define CLK_NS 8
`define PROG_BUSY_CYCLES ((`PROG_BUSY_NS + `CLK_NS - 1) / `CLK_NS)
`endif

//--- common/modem_status_pkg.sv
// types shared by both ends of the modem status and control link
package modem_status_pkg;
    typedef enum logic [1:0] {OP_IDLE, OP_RX, OP_TX} op_mode_type;
    typedef enum logic [2:0] {FMT0, FMT1, FMT2, FMT3, FMT4, FMT5, FMT6, FMT7} format_type;
    // events reported by the modem core, one-cycle pulses
    typedef struct packed {
        logic dtmf;
        logic aux2;
        logic aux1;
        logic frameSync;
        logic headOk;
        logic rateIs2400;
        logic rxData;
        logic rxLast;
        logic crcBad;
        logic txNeed;
        logic txLastBit;
    } modem_events_type;
endpackage

//--- common/modem_status_if.sv
// register port between the host-side controller and the modem status block
`timescale 1ns/1ns
interface modem_status_if;
    logic req;
    logic write;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic ack;
    logic [15:0] rdata;
    logic interruptOut_n;
    modport device (input req, input write, input addr, input wdata,
        output ack, output rdata, output interruptOut_n);
    modport host (output req, output write, output addr, output wdata,
        input ack, input rdata, input interruptOut_n);
endinterface

//--- hdl/modem_status_and_control.sv
// device end: event status, interrupt mask, modem configuration and program port
//
// Overview of operation
// R1 - summary flag set on any enabled status change; a change of port free (bit 0) never sets it
// R2 - interrupt pin low when summary and global mask
// R3 - DTMF flag on valid tone detection
// R4 - one threshold flag per auxiliary converter
// R5 - rx data end with ready and CRC update
// R6 - tx data end after last bit, marker gated
// R7 - data ready on tx need or rx data
// R8 - CRC flag on bad sized block CRC
// R9 - rate flag on sync or good head
// R10 - program port free; cleared by host write
// R11 - status read clears bits two to fifteen
// R12 - host ignores status during reset hold
// R13 - three sync pattern detect enables
// R14 - raw receive: sync, then 16-bit words
// R15 - packetised receive waits for complete head
// R16 - raw transmit 16 bits; host formats
// R17 - packetised transmit builds head from control byte
// R18 - host sets final marker for formats 0,2,3
// R19 - interleave heads when bit set
// R20 - three-bit format field decode
// R21 - user bit carried in frame head
// R22 - scrambler seed selection and descramble
// R23 - interrupt released when no enabled flag remains
`timescale 1ns/1ns
`include "modem_status_consts.svh"
module modem_status_and_control #(
    parameter int PROG_BUSY = `PROG_BUSY_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    modem_status_if.device regPort,
    // modem core side
    input wire modem_status_pkg::op_mode_type opMode,
    input wire modem_status_pkg::modem_events_type events,
    input wire logic [15:0] patternSeed1,
    input wire logic [15:0] patternSeed2,
    output logic [2:0] syncEnable,
    output logic rawMode,
    output logic interleaveHeads,
    output logic [2:0] msgFormat,
    output logic formatReserved,
    output logic [7:0] headControl,
    output logic [15:0] scrambleSeed,
    output logic [15:0] blockLoadWord,
    output logic blockLoadStrobe
);
    import modem_status_pkg::*;

    typedef struct packed {
        logic [15:0] status;
        logic [15:0] cfg;
        logic [15:0] irqMask;
        logic [15:0] rdata;
        logic ack;
        logic irqOut_n;
        logic [15:0] progWord;
        logic progStrobe;
        logic [7:0] progBusy;
        logic [15:0] seed;
        logic fmtReserved;
    } state_type;

    state_type state_reg, state_next;
    logic [15:0] setBits;
    logic rdStatus, wrConfig, wrProg, wrMask, sizedFmt, markerFmt;
    logic [2:0] fmt;

    // decoded requests; the device answers one cycle after req, one cycle per transfer
    assign rdStatus = regPort.req && !state_reg.ack && !regPort.write && regPort.addr == `OFS_EVENT_STATUS;
    assign wrConfig = regPort.req && !state_reg.ack && regPort.write && regPort.addr == `OFS_MODEM_CONFIG;
    assign wrProg = regPort.req && !state_reg.ack && regPort.write && regPort.addr == `OFS_BLOCK_LOAD;
    assign wrMask = regPort.req && !state_reg.ack && regPort.write && regPort.addr == `OFS_IRQ_MASK;
    assign fmt = state_reg.cfg[`FMT_HI:`FMT_LO];
    assign sizedFmt = fmt == `FMT_SIZED_CRC || fmt == `FMT_SIZED_ILV;
    assign markerFmt = fmt == `FMT_RAW || fmt == `FMT_UNSIZED_RAW || fmt == `FMT_UNSIZED_FEC;

    // event collection from the modem core
    always_comb begin
        setBits = 16'h0000;
        setBits[`BIT_DTMF] = events.dtmf; // see R3
        setBits[`BIT_AUX2] = events.aux2; // see R4
        setBits[`BIT_AUX1] = events.aux1; // see R4
        if (opMode == OP_RX) begin
            // head-only and sized frames end on their last part
            if (events.rxLast && (fmt == `FMT_HEAD_ONLY || sizedFmt)) begin
                setBits[`BIT_DATA_END] = 1'b1; // see R5
                setBits[`BIT_DATA_RDY] = 1'b1; // see R5
            end
            setBits[`BIT_DATA_RDY] = setBits[`BIT_DATA_RDY] | events.rxData; // see R7
            setBits[`BIT_CRC] = events.crcBad && sizedFmt && events.rxLast; // see R8
            // raw mode reports on frame sync, packetised only on a good head
            if ((fmt == `FMT_RAW && events.frameSync) || (fmt != `FMT_RAW && events.headOk)) begin
                setBits[`BIT_RATE_2K4] = events.rateIs2400; // see R9
                setBits[`BIT_RATE_1K2] = !events.rateIs2400; // see R9
            end
        end else if (opMode == OP_TX) begin
            setBits[`BIT_DATA_RDY] = events.txNeed; // see R7
            // unsized formats end only once the host has set the final-word marker
            setBits[`BIT_DATA_END] = events.txLastBit && (!markerFmt || state_reg.cfg[`BIT_LAST]); // see R6 R18
        end
    end

    // next state: sets win over read clears
    always_comb begin
        state_next = state_reg;
        state_next.ack = regPort.req && !state_reg.ack;
        state_next.progStrobe = 1'b0;
        if (rdStatus) begin
            state_next.rdata = state_reg.status;
            state_next.status = state_reg.status & ~`CLEAR_ON_READ; // see R11
        end else if (regPort.req && !state_reg.ack) begin
            state_next.rdata = 16'h0000;
        end
        state_next.status = state_next.status | (setBits & `STATUS_EVENTS);
        // summary flag follows any newly set and unmasked flag
        if (|(setBits & state_reg.irqMask & `STATUS_EVENTS)) begin
            state_next.status[`BIT_IRQ] = 1'b1; // see R1
        end
        if (wrConfig) begin
            state_next.cfg = regPort.wdata & `CFG_WRITABLE; // see R13 R19 R20 R21
        end
        if (wrMask) begin
            state_next.irqMask = regPort.wdata;
        end
        // program port: busy for a fixed time after each load word
        if (wrProg) begin
            state_next.progWord = regPort.wdata;
            state_next.progStrobe = 1'b1;
            state_next.progBusy = 8'(PROG_BUSY);
            state_next.status[`BIT_PORT_FREE] = 1'b0; // see R10
        end else if (state_reg.progBusy != 8'h00) begin
            state_next.progBusy = state_reg.progBusy - 8'h01;
        end else begin
            state_next.status[`BIT_PORT_FREE] = 1'b1; // see R10
        end
        // registered so the output comes straight from a flip-flop
        state_next.fmtReserved = state_next.cfg[`FMT_HI] && state_next.cfg[`FMT_LO + 1]; // see R20
        case (state_next.cfg[`SEED_HI:`SEED_LO])
            2'b00: state_next.seed = `SEED_STANDARD; // see R22
            2'b01: state_next.seed = patternSeed1;
            2'b10: state_next.seed = patternSeed2;
            default: state_next.seed = `SEED_NONE;
        endcase
        // pin released once the read has cleared the summary flag
        state_next.irqOut_n = !(state_next.status[`BIT_IRQ] && state_next.irqMask[`BIT_IRQ]); // see R2 R23
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= '{status: 16'h0000, cfg: 16'h0000, irqMask: 16'h0000, rdata: 16'h0000,
                ack: 1'b0, irqOut_n: 1'b1, progWord: 16'h0000, progStrobe: 1'b0, progBusy: 8'h00,
                seed: `SEED_STANDARD, fmtReserved: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign regPort.ack = state_reg.ack;
    assign regPort.rdata = state_reg.rdata;
    assign regPort.interruptOut_n = state_reg.irqOut_n;
    assign syncEnable = state_reg.cfg[`BIT_PAT_C:`BIT_PAT_T]; // see R13
    assign rawMode = state_reg.cfg[`BIT_RAW]; // see R14 R15 R16 R17
    assign interleaveHeads = state_reg.cfg[`BIT_INTERLEAVE]; // see R19
    assign msgFormat = fmt; // see R20
    assign formatReserved = state_reg.fmtReserved; // see R20
    assign headControl = state_reg.cfg[7:0]; // see R17 R21
    assign scrambleSeed = state_reg.seed; // see R22
    assign blockLoadWord = state_reg.progWord;
    assign blockLoadStrobe = state_reg.progStrobe;
endmodule

//--- hdl/modem_host_ctrl.sv
// host end: APB slave holding commands, drives the register port of the modem block
`timescale 1ns/1ns
`include "modem_status_consts.svh"
module modem_host_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // reset hold of the device, status is invalid while set
    input wire logic deviceHeld,
    // device register port
    modem_status_if.host devPort
);
    import modem_status_pkg::*;

    typedef enum logic [1:0] {IDLE, WAIT_ACK, DONE} step_type;
    typedef struct packed {
        step_type step;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic req;
        logic write;
        logic [7:0] addr;
        logic [15:0] wdata;
        logic [15:0] lastStatus;
    } state_type;
    state_type state_reg, state_next;
    // apb map: 0x00 command word (offset, write bit, data in the upper half), 0x08 last status, 0x0C pin
    logic access;
    assign access = psel && penable && !state_reg.ready;

    always_comb begin
        state_next = state_reg;
        state_next.ready = 1'b0;
        state_next.err = 1'b0;
        case (state_reg.step)
            IDLE: begin
                if (access) begin
                    if (paddr == 8'h00 && pwrite) begin
                        // a command starts one device access; apb waits until it ends
                        state_next.addr = pwdata[7:0];
                        state_next.write = pwdata[8];
                        state_next.wdata = pwdata[31:16];
                        state_next.req = 1'b1;
                        state_next.step = WAIT_ACK;
                    end else begin
                        state_next.ready = 1'b1;
                        state_next.err = paddr[1:0] != 2'b00 || paddr > 8'h0C;
                        case (paddr)
                            8'h08: state_next.rdata = {16'h0000, state_reg.lastStatus};
                            // the pin is a register on this same clock, so it needs no synchroniser
                            8'h0C: state_next.rdata = {31'h0, !devPort.interruptOut_n};
                            default: state_next.rdata = 32'h0000_0000;
                        endcase
                    end
                end
            end
            WAIT_ACK: begin
                if (devPort.ack) begin
                    state_next.req = 1'b0;
                    // held device gives invalid status; report zero instead
                    state_next.rdata = deviceHeld ? 32'h0 : {16'h0000, devPort.rdata}; // see R12
                    if (!state_reg.write && state_reg.addr == `OFS_EVENT_STATUS && !deviceHeld) begin
                        state_next.lastStatus = devPort.rdata;
                    end
                    state_next.ready = 1'b1;
                    state_next.step = DONE;
                end
            end
            DONE: state_next.step = IDLE;
            default: state_next.step = IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= '{step: IDLE, rdata: 32'h0, ready: 1'b0, err: 1'b0, req: 1'b0, write: 1'b0,
                addr: 8'h00, wdata: 16'h0000, lastStatus: 16'h0000};
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.rdata;
    assign pready = state_reg.ready;
    assign pslverr = state_reg.err;
    assign devPort.req = state_reg.req;
    assign devPort.write = state_reg.write;
    assign devPort.addr = state_reg.addr;
    assign devPort.wdata = state_reg.wdata;
endmodule

//--- testbench/modem_status_sva.sv
// interface checker for the modem status register port
`timescale 1ns/1ns
module modem_status_sva #(
    parameter int PROG_BUSY = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic req,
    input wire logic write,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic [15:0] rdata,
    input wire logic interruptOut_n
);
    int sinceLoad_reg;
    wire logic stRd = ack && !write && addr == 8'hC6;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // cycles since the last program port write; saturates so it never wraps
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sinceLoad_reg <= 1000;
        end else if (ack && write && addr == 8'hC8) begin
            sinceLoad_reg <= 0;
        end else if (sinceLoad_reg < 1000) begin
            sinceLoad_reg <= sinceLoad_reg + 1;
        end
    end
    a_ack_prompt: assert property (req && !ack |=> ack) else $error("no ack one cycle after request");
    a_ack_single: assert property (ack |=> !ack) else $error("ack longer than one cycle");
    a_req_holds: assert property (req && !ack |=> req && $stable(addr) && $stable(write))
        else $error("request changed before ack");
    a_rdata_held: assert property (!ack |-> $stable(rdata)) else $error("read data moved between acks");
    a_wo_zero: assert property (ack && !write && addr != 8'hC6 |-> rdata == 16'h0000)
        else $error("write-only or unmapped read not zero");
    a_irq_summary: assert property (!interruptOut_n && req && !ack && !write && addr == 8'hC6 |=> rdata[15])
        else $error("pin low but summary flag clear");
    a_prg_busy: assert property (stRd && sinceLoad_reg < PROG_BUSY - 2 |-> !rdata[0])
        else $error("program port free too soon");
    a_prg_free: assert property (stRd && sinceLoad_reg > PROG_BUSY + 3 |-> rdata[0])
        else $error("program port still busy");
endmodule

//--- testbench/modem_status_and_control_tb.sv
// self-checking bench for the modem status block and its host controller
`timescale 1ns/1ns
module modem_status_and_control_tb;
    import modem_status_pkg::*;
    localparam int PB = 8;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, deviceHeld = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, slvErr, strobe, rawMode, interleaveHeads, formatReserved;
    op_mode_type opMode = OP_IDLE;
    modem_events_type events = '0;
    logic [15:0] seed1 = 16'h1234, seed2 = 16'hABCD, scrambleSeed, blockLoadWord;
    logic [2:0] syncEnable, msgFormat;
    logic [7:0] headControl;
    int errCount = 0, nTests = 0, strobes = 0;
    modem_status_if link();
    always #4 clk = ~clk;
    // both ends of the link and the checker beside it
    modem_status_and_control #(.PROG_BUSY(PB)) modem_status_and_control_inst (.clk(clk), .rst(rst),
        .regPort(link.device), .opMode(opMode), .events(events), .patternSeed1(seed1), .patternSeed2(seed2),
        .syncEnable(syncEnable), .rawMode(rawMode), .interleaveHeads(interleaveHeads), .msgFormat(msgFormat),
        .formatReserved(formatReserved), .headControl(headControl), .scrambleSeed(scrambleSeed),
        .blockLoadWord(blockLoadWord), .blockLoadStrobe(strobe));
    modem_host_ctrl modem_host_ctrl_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .deviceHeld(deviceHeld), .devPort(link.host));
    modem_status_sva #(.PROG_BUSY(PB)) modem_status_sva_inst (.clk(clk), .rst(rst), .req(link.req),
        .write(link.write), .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata),
        .interruptOut_n(link.interruptOut_n));
    // program strobes are single pulses, so a count catches doubles
    always @(posedge clk) if (strobe === 1'b1) strobes <= strobes + 1;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer; waits for pready with a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("apb done", 1, pready);
    endtask
    // device register access carried on the command word
    task automatic dev(input logic wr, input logic [7:0] off, input logic [15:0] d);
        apb(1'b1, 8'h00, {d, 7'h00, wr, off});
    endtask
    task automatic ev_case(input logic [15:0] cfg, input op_mode_type op, input logic [10:0] ev,
        input logic [15:0] exp, input logic pin);
        dev(1'b1, 8'hC7, cfg);
        opMode <= op;
        @(posedge clk);
        events <= modem_events_type'(ev);
        @(posedge clk);
        events <= '0;
        repeat (4) @(posedge clk);
        apb(1'b0, 8'h0C, 32'h0);
        chk("irq pin", {31'h0, pin}, rd);
        dev(1'b0, 8'hC6, 16'h0000);
        chk("status", {16'h0, exp}, rd);
        apb(1'b0, 8'h08, 32'h0);
        chk("last status", {16'h0, exp}, rd);
        dev(1'b0, 8'hC6, 16'h0000);
        chk("status cleared", 32'h1, rd);
        repeat (3) @(posedge clk);
        apb(1'b0, 8'h0C, 32'h0);
        chk("irq released", 32'h0, rd);
        $display("event case %h done", ev);
    endtask
    task automatic t_config;
        logic [15:0] cfg;
        logic [15:0] seeds [4];
        seeds = '{16'hFFFF, seed1, seed2, 16'h0000};
        for (int i = 0; i < 8; i++) begin
            cfg = {i[2:0], 2'b00, i[0], 1'b0, i[1], i[2:0], 2'b00, 1'b1, i[1:0]};
            dev(1'b1, 8'hC7, cfg);
            repeat (2) @(posedge clk);
            chk("sync enables", i[2:0], syncEnable);
            chk("raw mode", i[0], rawMode);
            chk("interleave", i[1], interleaveHeads);
            chk("format", i[2:0], msgFormat);
            chk("reserved format", i > 5, formatReserved);
            chk("head control", cfg[7:0], headControl);
            chk("seed", seeds[i[1:0]], scrambleSeed);
        end
        dev(1'b0, 8'hC7, 16'h0000);
        chk("config readback", 32'h0, rd);
        dev(1'b1, 8'hC7, 16'h0000);
        $display("config test done");
    endtask
    task automatic t_prog;
        dev(1'b1, 8'hC8, 16'h5A3C);
        dev(1'b0, 8'hC6, 16'h0000);
        chk("port busy", 32'h0, rd);
        chk("load word", 16'h5A3C, blockLoadWord);
        chk("load strobes", 1, strobes);
        repeat (PB + 4) @(posedge clk);
        dev(1'b0, 8'hC6, 16'h0000);
        chk("port free", 32'h1, rd);
        $display("program port test done");
    endtask
    task automatic t_held;
        deviceHeld <= 1'b1;
        dev(1'b0, 8'hC6, 16'h0000);
        chk("held status", 32'h0, rd);
        deviceHeld <= 1'b0;
        apb(1'b0, 8'h10, 32'h0);
        chk("bad address", 1, slvErr);
        $display("hold test done");
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // watchdog well beyond the several hundred cycles the tests need
    initial begin
        #200000;
        errCount++;
        results;
    end
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        dev(1'b0, 8'hC6, 16'h0000);
        chk("reset status", 32'h1, rd);
        dev(1'b1, 8'hCE, 16'hFFFF);
        ev_case(16'h0000, OP_RX, 11'h400, 16'h9001, 1'b1);
        ev_case(16'h0000, OP_RX, 11'h200, 16'h8201, 1'b1);
        ev_case(16'h0000, OP_RX, 11'h100, 16'h8101, 1'b1);
        ev_case(16'h0000, OP_RX, 11'h0A0, 16'h8011, 1'b1);
        ev_case(16'h0000, OP_RX, 11'h080, 16'h8009, 1'b1);
        ev_case(16'h0080, OP_RX, 11'h080, 16'h0001, 1'b0);
        ev_case(16'h0080, OP_RX, 11'h060, 16'h8011, 1'b1);
        ev_case(16'h0000, OP_RX, 11'h010, 16'h8041, 1'b1);
        ev_case(16'h0080, OP_RX, 11'h01C, 16'h80E1, 1'b1);
        ev_case(16'h0020, OP_RX, 11'h018, 16'h80C1, 1'b1);
        ev_case(16'h0000, OP_TX, 11'h002, 16'h8041, 1'b1);
        ev_case(16'h0000, OP_TX, 11'h001, 16'h0001, 1'b0);
        ev_case(16'h0200, OP_TX, 11'h001, 16'h8081, 1'b1);
        ev_case(16'h0080, OP_TX, 11'h001, 16'h8081, 1'b1);
        dev(1'b1, 8'hCE, 16'h1000);
        ev_case(16'h0000, OP_RX, 11'h100, 16'h0101, 1'b0);
        ev_case(16'h0000, OP_RX, 11'h400, 16'h9001, 1'b0);
        t_config;
        t_prog;
        t_held;
        results;
    end
endmodule
